// ==== logic/abd_detector.sv ====
// Auto-baud rate detector: times a 55h sync character into a 16-bit divisor.
`timescale 1ns/1ps
module ard_detector (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        rx_pin,
  output logic             receiver_hold,
  output logic             irq
);
  import ard_pkg::*;

  // ****************************************************
  // Receive line synchroniser
  // ****************************************************
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;

  // All stages reset to the idle level of the line, so no false edge follows reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  wire rx_rise = rx_sync && !rx_prev;
  wire rx_fall = !rx_sync && rx_prev;

  // ****************************************************
  // Registers
  // ****************************************************
  logic [7:0]  control;
  logic [15:0] rate_divisor;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [2:0]  edges;
  ard_state_t  state;
  ard_state_t  next_state;

  wire autobaud_request     = control[BIT_REQUEST];
  wire wake_on_break_enable = control[BIT_WAKE];
  wire wide_divisor_select  = control[BIT_WIDE];
  wire high_speed_select    = control[BIT_HIGH];

  wire wr_control = wr && (addr == ADDR_CONTROL);
  wire wr_low     = wr && (addr == ADDR_COUNT_LOW);
  wire wr_high    = wr && (addr == ADDR_COUNT_HIGH);
  wire wr_status  = wr && (addr == ADDR_STATUS);
  wire wr_mask    = wr && (addr == ADDR_MASK);
  wire rd_buffer  = rd && (addr == ADDR_RX_BUFFER);

  wire start_req = wr_control && wdata[BIT_REQUEST] && !autobaud_request;
  // A write that keeps the request set while a sequence runs only changes the selects.
  wire sw_abort  = wr_control && !wdata[BIT_REQUEST] && (state != ARD_IDLE);

  // ****************************************************
  // Measurement clock
  // ****************************************************
  logic tick;
  wire  counting = (state == ARD_COUNT);

  // The divider restarts with every measurement, so the first step is a full period.
  ard_rate_tick u_tick (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .clear               (!counting),
    .wide_divisor_select (wide_divisor_select),
    .high_speed_select   (high_speed_select),
    .tick                (tick)
  );

  wire final_edge = counting && rx_rise && (edges == EDGES_TOTAL - 3'h1);
  wire done       = final_edge;

  // ****************************************************
  // Sequence control
  // ****************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ARD_IDLE: begin
        if (start_req) begin
          // A break precedes the character when wake is armed.
          next_state = wdata[BIT_WAKE] ? ARD_BREAK_LOW : ARD_WAIT_START;
        end
      end
      ARD_BREAK_LOW: begin
        if (rx_fall || !rx_sync) begin
          next_state = ARD_BREAK_HIGH;
        end
      end
      ARD_BREAK_HIGH: begin
        if (rx_rise) begin
          next_state = ARD_WAIT_START;
        end
      end
      ARD_WAIT_START: begin
        if (rx_fall) begin
          next_state = ARD_WAIT_RISE;
        end
      end
      ARD_WAIT_RISE: begin
        if (rx_rise) begin
          next_state = ARD_COUNT;
        end
      end
      ARD_COUNT: begin
        if (final_edge) begin
          next_state = ARD_IDLE;
        end
      end
    endcase
    if (sw_abort) begin
      next_state = ARD_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ARD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************
  // Edge count and divisor counter
  // ****************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      edges <= 3'h0;
    end else if (state == ARD_WAIT_RISE && rx_rise) begin
      edges <= 3'h1;
    end else if (counting && rx_rise) begin
      edges <= edges + 3'h1;
    end
  end

  // The measurement tick, not the line, paces one 16-bit counter whatever the wide select.
  // Software may preload the divisor only while idle; a write mid-sequence is lost.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_divisor <= 16'h0000;
    end else if (state == ARD_WAIT_RISE && rx_rise) begin
      rate_divisor <= COUNT_START;
    end else if (counting && tick && !final_edge) begin
      rate_divisor <= rate_divisor + 16'h0001;
    end else if (!counting && state == ARD_IDLE && wr_low) begin
      rate_divisor[7:0] <= wdata;
    end else if (!counting && state == ARD_IDLE && wr_high) begin
      rate_divisor[15:8] <= wdata;
    end
  end

  // ****************************************************
  // Control, status, mask
  // ****************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control <= CONTROL_RESET;
    end else if (done) begin
      control <= control & ~(8'h01 << BIT_REQUEST);
    end else if (wr_control) begin
      control <= wdata;
    end
  end

  // Set wins over clear, whether the clear is a buffer read or a write of one.
  wire [1:0] set_bits = {done, done};
  wire [1:0] clr_bits = (wr_status ? wdata[1:0] : 2'h0) | {1'b0, rd_buffer};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status <= 2'h0;
      mask   <= MASK_RESET;
    end else begin
      status <= (status & ~clr_bits) | set_bits;
      if (wr_mask) begin
        mask <= wdata[1:0];
      end
    end
  end

  // ****************************************************
  // Read port and outputs
  // ****************************************************
  wire [7:0] read_mux =
    (addr == ADDR_CONTROL)    ? control :
    (addr == ADDR_COUNT_LOW)  ? rate_divisor[7:0] :
    (addr == ADDR_COUNT_HIGH) ? rate_divisor[15:8] :
    (addr == ADDR_STATUS)     ? {6'h00, status} :
    (addr == ADDR_MASK)       ? {6'h00, mask} : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata         <= 8'h00;
      receiver_hold <= 1'b0;
      irq           <= 1'b0;
    end else begin
      // The buffer address reads as zero: its content is meaningless here.
      rdata         <= rd ? read_mux : 8'h00;
      receiver_hold <= (next_state != ARD_IDLE);
      irq           <= |((((status & ~clr_bits) | set_bits)) & mask);
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_done_clears_req: assert property (@(posedge ref_clk) disable iff (rst)
    done |=> !control[BIT_REQUEST] && status[BIT_RXF])
    else $error("request not cleared or flag not set at completion");

  a_count_starts_one: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ARD_WAIT_RISE && rx_rise) |=> rate_divisor == 16'h0001)
    else $error("counter did not start at one");

  a_hold_during_cal: assert property (@(posedge ref_clk) disable iff (rst)
    (state != ARD_IDLE) |-> receiver_hold)
    else $error("receiver not held during calibration");

  a_abort_no_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (sw_abort && !done && !status[BIT_RXF]) |=> !status[BIT_RXF] && state == ARD_IDLE)
    else $error("abort set the flag or left the sequence running");

  a_read_clears_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_buffer && !done) |=> !status[BIT_RXF])
    else $error("buffer read did not clear the flag");

  a_counter_steady: assert property (@(posedge ref_clk) disable iff (rst)
    (counting && !tick) |=> $stable(rate_divisor))
    else $error("counter moved without a measurement tick");

  a_count_on_tick: assert property (@(posedge ref_clk) disable iff (rst)
    (counting && tick && !final_edge) |=> rate_divisor == $past(rate_divisor) + 16'h0001)
    else $error("counter missed a tick");

  a_fifth_edge_stop: assert property (@(posedge ref_clk) disable iff (rst)
    final_edge |=> state == ARD_IDLE && edges == EDGES_TOTAL)
    else $error("measurement stopped on the wrong edge");

  a_break_skipped: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ARD_BREAK_LOW || state == ARD_BREAK_HIGH) |=> $stable(rate_divisor))
    else $error("break character was measured");

  a_start_on_rise: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ARD_WAIT_RISE && rx_rise && !sw_abort) |=> counting)
    else $error("counting did not start at the first rising edge");

  a_edge_once: assert property (@(posedge ref_clk) disable iff (rst)
    rx_rise |=> !rx_rise)
    else $error("one rising edge was seen twice");

  a_high_carry: assert property (@(posedge ref_clk) disable iff (rst)
    (counting && tick && !final_edge && rate_divisor[7:0] == 8'hFF)
      |=> rate_divisor[15:8] == $past(rate_divisor[15:8]) + 8'h01)
    else $error("low byte did not carry into the high byte");

  a_irq_follows_mask: assert property (@(posedge ref_clk) disable iff (rst)
    irq == |(status & $past(mask)))
    else $error("interrupt does not follow the unmasked status");

  a_buffer_reads_zero: assert property (@(posedge ref_clk) disable iff (rst)
    rd_buffer |=> rdata == 8'h00)
    else $error("receive buffer read returned data");

  a_hold_drops_done: assert property (@(posedge ref_clk) disable iff (rst)
    done |=> !receiver_hold)
    else $error("receiver still held after completion");

  a_abort_drops_hold: assert property (@(posedge ref_clk) disable iff (rst)
    sw_abort |=> !receiver_hold)
    else $error("receiver still held after abort");

endmodule

// ==== logic/abd_pkg.sv ====
// Shared constants for the auto-baud rate detector.
package ard_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [3:0] ADDR_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_COUNT_LOW  = 4'h1;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h2;
  localparam logic [3:0] ADDR_RX_BUFFER  = 4'h3;
  localparam logic [3:0] ADDR_STATUS     = 4'h4;
  localparam logic [3:0] ADDR_MASK       = 4'h5;

  // ****************************************************
  // Control field positions
  // ****************************************************
  localparam int BIT_REQUEST = 0;
  localparam int BIT_WAKE    = 1;
  localparam int BIT_WIDE    = 2;
  localparam int BIT_HIGH    = 3;

  // Status bits: 0 = receive flag, 1 = measurement done.
  localparam int BIT_RXF  = 0;
  localparam int BIT_DONE = 1;

  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [1:0]  MASK_RESET    = 2'h0;
  localparam logic [15:0] COUNT_START   = 16'h0001;
  localparam logic [2:0]  EDGES_TOTAL   = 3'h5;

  // Measurement clock dividers in system clocks.
  localparam logic [8:0] DIV_SLOW = 9'h1FF;
  localparam logic [8:0] DIV_MID  = 9'h07F;
  localparam logic [8:0] DIV_FAST = 9'h01F;

  typedef enum logic [2:0] {
    ARD_IDLE, ARD_BREAK_LOW, ARD_BREAK_HIGH, ARD_WAIT_START, ARD_WAIT_RISE, ARD_COUNT
  } ard_state_t;

endpackage

// ==== logic/abd_rate_tick.sv ====
// Measurement clock enable divider for the auto-baud detector.
`timescale 1ns/1ps
module ard_rate_tick (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       wide_divisor_select,
  input  wire logic       high_speed_select,
  output logic            tick
);
  import ard_pkg::*;

  logic [8:0] count;
  wire  [1:0] sel = {1'b0, wide_divisor_select} + {1'b0, high_speed_select};
  // Both selects clear tick every 512 clocks, one set every 128, both set every 32.
  wire  [8:0] limit = (sel == 2'h0) ? DIV_SLOW : (sel == 2'h1) ? DIV_MID : DIV_FAST;
  wire        wrap  = (count >= limit);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= 9'h000;
      tick  <= 1'b0;
    end else begin
      count <= (clear || wrap) ? 9'h000 : count + 9'h001;
      tick  <= wrap && !clear;
    end
  end
endmodule

// ==== dv/abd_remote_tx.sv ====
// Remote serial transmitter model that sends the sync character.
`timescale 1ns/1ps
module ard_remote_tx (
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [15:0] bit_clks,
  input  wire logic        with_break,
  output logic             rx_line,
  output logic             busy
);
  localparam logic [7:0] SYNC_CHAR = 8'h55;

  // The line idles high between characters, as an asynchronous line must.
  initial begin
    rx_line = 1'b1;
    busy    = 1'b0;
    forever begin
      @(posedge ref_clk);
      while (!go) begin
        @(posedge ref_clk);
      end
      busy <= 1'b1;
      if (with_break) begin
        rx_line <= 1'b0;
        repeat (13 * bit_clks) @(posedge ref_clk);
        rx_line <= 1'b1;
        repeat (2 * bit_clks) @(posedge ref_clk);
      end
      rx_line <= 1'b0;
      repeat (bit_clks) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        rx_line <= SYNC_CHAR[i];
        repeat (bit_clks) @(posedge ref_clk);
      end
      rx_line <= 1'b1;
      repeat (bit_clks) @(posedge ref_clk);
      busy <= 1'b0;
    end
  end
endmodule

// ==== dv/test_autobaud_rate_detector.sv ====
// Self-checking testbench for the auto-baud rate detector.
`timescale 1ns/1ps
module test_autobaud_rate_detector;
  import ard_pkg::*;

  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end

  logic        ref_clk;
  logic        rst;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        rx_line;
  logic        receiver_hold;
  logic        irq;
  logic        tx_go;
  logic [15:0] tx_bits;
  logic        tx_brk;
  logic        tx_busy;
  int          num_errors;
  int          num_checks;

  ard_detector u_dut (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .addr          (addr),
    .wdata         (wdata),
    .wr            (wr),
    .rd            (rd),
    .rdata         (rdata),
    .rx_pin        (rx_line),
    .receiver_hold (receiver_hold),
    .irq           (irq)
  );

  ard_remote_tx u_remote (
    .ref_clk    (ref_clk),
    .go         (tx_go),
    .bit_clks   (tx_bits),
    .with_break (tx_brk),
    .rx_line    (rx_line),
    .busy       (tx_busy)
  );

  // ****************************************************
  // Bus and line helpers
  // ****************************************************
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic check_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  task automatic send_char(input logic [15:0] b, input logic brk);
    @(posedge ref_clk);
    tx_bits <= b;
    tx_brk  <= brk;
    tx_go   <= 1'b1;
    @(posedge ref_clk);
    tx_go <= 1'b0;
  endtask

  // Bounded wait so a stuck calibration cannot hang the run.
  task automatic wait_idle();
    int n;
    n = 0;
    while ((receiver_hold !== 1'b0 || tx_busy !== 1'b0) && n < 60000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 60000) begin
      `CHK(n, 0)
    end
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic run_mode(input logic [7:0] ctrl, input logic [15:0] b, input logic [15:0] e);
    reg_write(ADDR_MASK, 8'h00);
    reg_write(ADDR_CONTROL, ctrl);
    @(posedge ref_clk);
    #1;
    `CHK(receiver_hold, 1'b1)
    send_char(b, ctrl[BIT_WAKE]);
    wait_idle();
    check_reg(ADDR_COUNT_LOW, e[7:0]);
    check_reg(ADDR_COUNT_HIGH, e[15:8]);
    check_reg(ADDR_CONTROL, ctrl & 8'hFE);
    check_reg(ADDR_STATUS, 8'h03);
    `CHK(irq, 1'b0)
    reg_write(ADDR_MASK, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(irq, 1'b1)
    check_reg(ADDR_RX_BUFFER, 8'h00);
    check_reg(ADDR_STATUS, 8'h02);
    reg_write(ADDR_STATUS, 8'h02);
    check_reg(ADDR_STATUS, 8'h00);
    `CHK(irq, 1'b0)
    $display("test run_mode ctrl %h finished", ctrl);
  endtask

  task automatic test_abort();
    reg_write(ADDR_CONTROL, 8'h0D);
    send_char(16'd102, 1'b0);
    repeat (300) @(posedge ref_clk);
    reg_write(ADDR_CONTROL, 8'h0C);
    @(posedge ref_clk);
    #1;
    `CHK(receiver_hold, 1'b0)
    wait_idle();
    check_reg(ADDR_STATUS, 8'h00);
    reg_write(ADDR_CONTROL, 8'h0D);
    send_char(16'd102, 1'b0);
    repeat (300) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wait_idle();
    check_reg(ADDR_STATUS, 8'h00);
    check_reg(ADDR_CONTROL, 8'h00);
    check_reg(4'hF, 8'h00);
    $display("test abort finished");
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Bit times sit half a tick off a tick boundary so sync delay cannot flip a count.
  initial begin
    num_errors = 0;
    num_checks = 0;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    tx_go = 1'b0;
    tx_bits = 16'h0064;
    tx_brk = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    run_mode(8'h01, 16'd1632, 16'h001A);
    run_mode(8'h05, 16'd408, 16'h001A);
    run_mode(8'h09, 16'd408, 16'h001A);
    run_mode(8'h0D, 16'd102, 16'h001A);
    run_mode(8'h0D, 16'd2654, 16'h0298);
    run_mode(8'h0F, 16'd102, 16'h001A);
    test_abort();
    summarize();
  end

  // The scenarios need about 57,000 cycles; the watchdog allows 80,000.
  initial begin
    #800000;
    num_errors++;
    summarize();
  end
endmodule
